//--- hw/pag_guard.sv
// Lock state, key words and access gate of the secure memory guard
`timescale 1ns/1ps
module pag_guard (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_in,
  input  wire pag_pkg::pag_req_t    req_in,
  output logic                      grant_out,
  input  wire logic                 mem_rd_valid_in,
  input  wire logic [15:0]          mem_rd_data_in,
  output logic                      rd_valid_out,
  output logic [15:0]               rd_data_out,
  input  wire logic [127:0]         stored_password_words_in,
  input  wire pag_pkg::pag_key_wr_t key_wr_in,
  input  wire logic                 protected_write_enable_in,
  input  wire logic                 force_lock_bit_in,
  output logic [15:0]               security_status_control_out,
  output logic                      locked_out
);

  // ************************************************************
  // State
  // ************************************************************
  pag_pkg::pag_state_t state;
  pag_pkg::pag_state_t next_state;
  logic [7:0]          rd_mask;
  logic [7:0]          next_rd_mask;
  logic [127:0]        keys;
  logic [127:0]        next_keys;
  logic                zero_pend;
  logic                next_zero_pend;
  logic                rd_valid;
  logic                next_rd_valid;
  logic [15:0]         rd_data;
  logic [15:0]         next_rd_data;

  logic pwd_ones;
  logic pwd_zero;
  logic key_match;
  logic locked;
  logic pwd_hit;
  logic pwd_rd;
  logic [2:0] pwd_idx;

  pag_pwd_cmp #(
    .WORDS (pag_pkg::KEY_WORDS),
    .WW    (pag_pkg::WORD_W)
  ) u_cmp (
    .pwd_in       (stored_password_words_in), // [R07]
    .key_in       (keys),
    .all_ones_out (pwd_ones),
    .all_zero_out (pwd_zero),
    .match_out    (key_match)
  );

  assign locked  = state != pag_pkg::ST_UNLOCKED;
  assign pwd_hit = req_in.addr[21:3] == pag_pkg::PWD_BASE[21:3];
  assign pwd_idx = req_in.addr[2:0];
  assign pwd_rd  = req_in.valid && pwd_hit && req_in.kind == pag_pkg::KIND_READ;

  // ************************************************************
  // Access gate
  // ************************************************************
  always_comb begin
    grant_out = 1'b0;
    if (req_in.valid) begin
      if (!req_in.secure || !locked) begin
        grant_out = 1'b1; // [R13]
      end else if (req_in.kind == pag_pkg::KIND_FETCH) begin
        grant_out = req_in.src != pag_pkg::SRC_DEBUG; // [R09]
      end else if (pwd_rd) begin
        grant_out = 1'b1; // [R02]
      end else begin
        grant_out = req_in.src == pag_pkg::SRC_CPU_SECURE; // [R10] [R11] [R12] [R14]
      end
    end
  end

  // ************************************************************
  // Unlock sequence
  // ************************************************************
  always_comb begin
    next_state   = state;
    next_rd_mask = rd_mask;
    if (force_lock_bit_in) begin
      next_state   = pag_pkg::ST_LOCKED; // [R16]
      next_rd_mask = 8'h00;
    end else begin
      case (state)
        pag_pkg::ST_LOCKED: begin
          if (pwd_rd) begin
            next_rd_mask[pwd_idx] = 1'b1; // [R20]
          end
          if (&next_rd_mask) begin
            next_state = pag_pkg::ST_ARMED; // [R01]
          end
        end
        pag_pkg::ST_ARMED: begin
          if (pwd_zero) begin
            next_state = pag_pkg::ST_ARMED; // [R04]
          end else if (pwd_ones || key_match) begin
            next_state = pag_pkg::ST_UNLOCKED; // [R03] [R05] [R19]
          end
        end
        pag_pkg::ST_UNLOCKED: begin
          next_state = pag_pkg::ST_UNLOCKED;
        end
        default: begin
          next_state = pag_pkg::ST_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state   <= pag_pkg::ST_LOCKED; // [R06]
      rd_mask <= 8'h00;
    end else begin
      state   <= next_state;
      rd_mask <= next_rd_mask;
    end
  end

  // ************************************************************
  // Key words
  // ************************************************************
  always_comb begin
    next_keys = keys;
    if (force_lock_bit_in) begin
      next_keys = {pag_pkg::KEY_WORDS{pag_pkg::KEY_CLEARED}}; // [R16]
    end else if (key_wr_in.wr && protected_write_enable_in) begin
      next_keys[key_wr_in.idx*pag_pkg::WORD_W +: pag_pkg::WORD_W] = key_wr_in.data; // [R15]
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      keys <= {pag_pkg::KEY_WORDS{pag_pkg::KEY_RESET}}; // [R18]
    end else begin
      keys <= next_keys;
    end
  end

  // ************************************************************
  // Read data path
  // ************************************************************
  always_comb begin
    next_zero_pend = pwd_rd && locked;
    next_rd_valid  = mem_rd_valid_in;
    next_rd_data   = zero_pend ? 16'h0000 : mem_rd_data_in; // [R02]
    if (!mem_rd_valid_in) begin
      next_rd_data = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      zero_pend <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 16'h0000;
    end else begin
      zero_pend <= next_zero_pend;
      rd_valid  <= next_rd_valid;
      rd_data   <= next_rd_data;
    end
  end

  assign rd_valid_out = rd_valid;
  assign rd_data_out  = rd_data;
  assign locked_out   = locked;
  assign security_status_control_out = {1'b0, pag_pkg::STAT_RESERVED, locked}; // [R16] [R17]

  // ************************************************************
  // Checks
  // ************************************************************
  sequence seq_reads_done;
    rd_mask == 8'hFF;
  endsequence

  sequence seq_masked_read;
    pwd_rd && locked && !force_lock_bit_in ##1 mem_rd_valid_in;
  endsequence

  AST_PWD_ZERO: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R02]
    seq_masked_read |=> rd_valid_out && rd_data_out == 16'h0000)
    else $error("password read not zeroed");

  AST_RESET_LOCK: assert property (@(posedge clk_sys_in) // [R06]
    $fell(rst_in) |-> locked && rd_mask == 8'h00)
    else $error("not locked after reset");

  AST_ONES_UNLOCK: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R03]
    state == pag_pkg::ST_ARMED && pwd_ones && !force_lock_bit_in |=> !locked_out)
    else $error("all-ones password did not unlock");

  AST_ZERO_STAYS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R04]
    locked && pwd_zero |=> locked_out)
    else $error("zero password unlocked");

  AST_FETCH: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R09]
    req_in.valid && req_in.kind == pag_pkg::KIND_FETCH && req_in.src != pag_pkg::SRC_DEBUG |-> grant_out)
    else $error("fetch refused");

  AST_UNSEC_BLOCK: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R10]
    req_in.valid && req_in.secure && locked && !pwd_hit && req_in.kind != pag_pkg::KIND_FETCH
    && req_in.src != pag_pkg::SRC_CPU_SECURE |-> !grant_out)
    else $error("locked data access granted");

  AST_SEC_DATA: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R14]
    req_in.valid && req_in.secure && req_in.src == pag_pkg::SRC_CPU_SECURE |-> grant_out)
    else $error("secure code data access refused");

  AST_UNLOCKED_FULL: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R13]
    req_in.valid && !locked |-> grant_out)
    else $error("unlocked access refused");

  AST_KEY_GUARD: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R15]
    !protected_write_enable_in && !force_lock_bit_in |=> $stable(keys))
    else $error("unprotected key write");

  AST_FORCE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R16]
    force_lock_bit_in |=> locked_out && keys == 128'h0 && !security_status_control_out[15])
    else $error("force lock failed");

  AST_NO_EARLY: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R20]
    !locked_out |-> seq_reads_done)
    else $error("unlock before dummy reads");

  AST_STATUS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R17]
    security_status_control_out[0] == locked_out)
    else $error("status lock bit wrong");

endmodule : pag_guard

//--- hw/pag_pkg.sv
// Constants and types of the password unlock access guard
// Notes on behaviour
// R01: Unlocking takes eight dummy password reads, then eight key word writes.
// R02: While locked, every password word read returns zero.
// R03: All-ones password unlocks once the dummy reads finish, no key writes.
// R04: All-zero password keeps the device locked forever, whatever keys hold.
// R05: Other passwords unlock only when all eight key words match.
// R06: Every reset locks the device, even with an all-ones password.
// R07: The 128-bit password comes from eight consecutive flash words.
// R08: Flash words just below the password should hold zero, unused.
// R09: Instruction fetches from secure memory are always allowed; the code refuses fetches from the debug source while locked.
// R10: While locked, writes to secure memory from unsecure code are blocked.
// R11: While locked, data reads of secure memory from unsecure code are blocked; the code grants password word reads, which return zero.
// R12: While locked, debug reads and writes of secure memory are refused; the code grants debug password word reads, which return zero.
// R13: While unlocked, CPU and debug get full secure memory access.
// R14: While locked, secure data access only from code running in secure memory.
// R15: Key writes are ignored unless the protected write enable is active.
// R16: Force lock bit clears all keys and locks; it always reads zero.
// R17: Status bit 0 reads one while locked, zero while unlocked.
// R18: Each of the eight 16-bit key words resets to all ones.
// R19: Keys are compared continuously; unlock as soon as all words match.
// R20: Dummy read progress is tracked; no unlock before all eight are read.
package pag_pkg;

  // ************************************************************
  // Sizes and addresses
  // ************************************************************
  localparam int          WORD_W      = 16;
  localparam int          KEY_WORDS   = 8;
  localparam int          ADDR_W      = 22;
  localparam int          IDX_W       = 3;
  localparam logic [21:0] PWD_BASE    = 22'h3F7FF8;
  localparam logic [15:0] KEY_RESET   = 16'hFFFF;
  localparam logic [15:0] KEY_CLEARED = 16'h0000;

  // ************************************************************
  // Status word layout
  // ************************************************************
  localparam int          STAT_LOCK_BIT  = 0;
  localparam int          STAT_FORCE_BIT = 15;
  localparam logic [13:0] STAT_RESERVED  = 14'h0017;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    KIND_FETCH = 2'h0,
    KIND_READ  = 2'h1,
    KIND_WRITE = 2'h2
  } pag_kind_t;

  typedef enum logic [1:0] {
    SRC_CPU_SECURE   = 2'h0,
    SRC_CPU_UNSECURE = 2'h1,
    SRC_DEBUG        = 2'h2
  } pag_src_t;

  typedef enum logic [2:0] {
    ST_LOCKED   = 3'h1,
    ST_ARMED    = 3'h2,
    ST_UNLOCKED = 3'h4
  } pag_state_t;

  typedef struct packed {
    logic              valid;
    logic [21:0]       addr;
    logic              secure;
    pag_kind_t         kind;
    pag_src_t          src;
  } pag_req_t;

  typedef struct packed {
    logic              wr;
    logic [2:0]        idx;
    logic [15:0]       data;
  } pag_key_wr_t;

endpackage : pag_pkg

//--- hw/pag_pwd_cmp.sv
// Password classifier and key comparator
`timescale 1ns/1ps
module pag_pwd_cmp #(
  parameter int WORDS = 8,
  parameter int WW    = 16
) (
  input  wire logic [WORDS*WW-1:0] pwd_in,
  input  wire logic [WORDS*WW-1:0] key_in,
  output logic                     all_ones_out,
  output logic                     all_zero_out,
  output logic                     match_out
);

  if (WORDS < 1 || WW < 1) begin : g_bad_size
    $error("pag_pwd_cmp: bad size");
  end

  logic [WORDS-1:0] w_ones;
  logic [WORDS-1:0] w_zero;
  logic [WORDS-1:0] w_match;

  // ************************************************************
  // Per word tests
  // ************************************************************
  for (genvar g = 0; g < WORDS; g++) begin : g_word
    assign w_ones[g]  = &pwd_in[g*WW +: WW];
    assign w_zero[g]  = ~|pwd_in[g*WW +: WW];
    assign w_match[g] = pwd_in[g*WW +: WW] == key_in[g*WW +: WW];
  end

  assign all_ones_out = &w_ones;
  assign all_zero_out = &w_zero;
  assign match_out    = &w_match; // [R19]

endmodule : pag_pwd_cmp

//--- sim/pag_mem_model.sv
// Memory side model answering reads one cycle after the request
`timescale 1ns/1ps
module pag_mem_model (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire pag_pkg::pag_req_t req_in,
  input  wire logic [127:0]      pwd_in,
  output logic                   mem_rd_valid_out,
  output logic [15:0]            mem_rd_data_out
);
  // ************************************************************
  // Read answer
  // ************************************************************
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_rd_valid_out <= 1'b0;
      mem_rd_data_out  <= 16'h0000;
    end else if (req_in.valid && req_in.kind == pag_pkg::KIND_READ) begin
      mem_rd_valid_out <= 1'b1;
      if (req_in.addr[21:3] == pag_pkg::PWD_BASE[21:3]) begin
        mem_rd_data_out <= pwd_in[{req_in.addr[2:0], 4'h0} +: 16];
      end else if (req_in.addr >= 22'h3F7F80 && req_in.addr <= 22'h3F7FF5) begin
        mem_rd_data_out <= 16'h0000;
      end else begin
        mem_rd_data_out <= req_in.addr[15:0];
      end
    end else begin
      // Released bus: valid drops, data inverts its last value
      mem_rd_valid_out <= 1'b0;
      mem_rd_data_out  <= ~mem_rd_data_out;
    end
  end
endmodule : pag_mem_model

//--- sim/tb_password_unlock_access_guard.sv
// Testbench of the password unlock access guard
`timescale 1ns/1ps
module tb_password_unlock_access_guard;
  logic                 clk_sys_in, rst_in, mem_v, pwe, frc, rdv, grant, locked, rd_zero;
  logic [15:0]          mem_d, rdd, stat;
  logic [127:0]         pwd;
  pag_pkg::pag_req_t    req;
  pag_pkg::pag_key_wr_t kw;
  int                   err_total, checked, rd_seen;

  pag_guard uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req), .grant_out(grant),
    .mem_rd_valid_in(mem_v), .mem_rd_data_in(mem_d), .rd_valid_out(rdv), .rd_data_out(rdd),
    .stored_password_words_in(pwd), .key_wr_in(kw), .protected_write_enable_in(pwe),
    .force_lock_bit_in(frc), .security_status_control_out(stat), .locked_out(locked));
  pag_mem_model u_mem (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req), .pwd_in(pwd),
    .mem_rd_valid_out(mem_v), .mem_rd_data_out(mem_d));

  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic do_reset(input logic [127:0] p);
    @(negedge clk_sys_in);
    pwd    = p;
    rst_in = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    rst_in = 1'b0;
  endtask : do_reset

  task automatic rd_all(input int first, input int n);
    for (int i = first; i < first + n; i++) begin
      @(negedge clk_sys_in);
      req.valid  = 1'b1;
      req.addr   = pag_pkg::PWD_BASE + 22'(i);
      req.secure = 1'b1;
      req.kind   = pag_pkg::KIND_READ;
      req.src    = pag_pkg::SRC_CPU_UNSECURE;
    end
    @(negedge clk_sys_in);
    req.valid = 1'b0;
  endtask : rd_all

  task automatic wkey(input int idx, input logic [15:0] d, input logic en);
    @(negedge clk_sys_in);
    pwe = en;
    kw  = '{1'b1, 3'(idx), d};
    @(negedge clk_sys_in);
    kw.wr = 1'b0;
    pwe   = 1'b0;
  endtask : wkey

  task automatic lock_is(input logic exp);
    repeat (3) @(negedge clk_sys_in);
    chk({15'h0000, locked}, {15'h0000, exp});
  endtask : lock_is

  task automatic gate_all(input logic lockd);
    logic e;
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 3; s++) begin
        @(negedge clk_sys_in);
        req = '{1'b1, 22'h3F0000, 1'b1, pag_pkg::pag_kind_t'(k), pag_pkg::pag_src_t'(s)};
        e = !lockd || s == 0 || (k == 0 && s == 1);
        #1 chk({15'h0000, grant}, {15'h0000, e});
      end
    end
    req.valid = 1'b0;
  endtask : gate_all

  // ************************************************************
  // Scenarios
  // ************************************************************
  always @(negedge clk_sys_in) begin
    if (rd_zero && rdv === 1'b1) begin
      rd_seen++;
      chk(rdd, 16'h0000);
    end
  end

  task automatic t_match;
    logic [127:0] p;
    p = 128'h8888_7777_6666_5555_4444_3333_2222_1111;
    do_reset(p);
    chk(stat, 16'h002F);
    gate_all(1'b1);
    rd_seen = 0;
    rd_zero = 1'b1;
    rd_all(0, 8);
    repeat (2) @(negedge clk_sys_in);
    rd_zero = 1'b0;
    chk(16'(rd_seen), 16'h0008);
    lock_is(1'b1);
    for (int i = 0; i < 8; i++) wkey(i, p[16*i +: 16], 1'b0);
    lock_is(1'b1);
    for (int i = 0; i < 7; i++) wkey(i, p[16*i +: 16], 1'b1);
    lock_is(1'b1);
    wkey(7, p[127:112], 1'b1);
    lock_is(1'b0);
    chk(stat, 16'h002E);
    gate_all(1'b0);
    @(negedge clk_sys_in);
    frc = 1'b1;
    @(negedge clk_sys_in);
    frc = 1'b0;
    lock_is(1'b1);
    chk(stat, 16'h002F);
    $display("test match done");
  endtask : t_match

  task automatic t_ones;
    do_reset({128{1'b1}});
    chk({15'h0000, locked}, 16'h0001);
    rd_all(0, 7);
    lock_is(1'b1);
    rd_all(7, 1);
    lock_is(1'b0);
    gate_all(1'b0);
    do_reset({128{1'b1}});
    chk({15'h0000, locked}, 16'h0001);
    $display("test all ones done");
  endtask : t_ones

  task automatic t_key_reset;
    do_reset({{64{1'b1}}, 16'h1234, {48{1'b1}}});
    wkey(3, 16'h1234, 1'b1);
    rd_all(0, 8);
    lock_is(1'b0);
    $display("test key reset done");
  endtask : t_key_reset

  task automatic t_zero;
    do_reset({128{1'b0}});
    for (int i = 0; i < 8; i++) wkey(i, 16'h0000, 1'b1);
    rd_all(0, 8);
    lock_is(1'b1);
    $display("test all zero done");
  endtask : t_zero

  initial begin
    rst_in    = 1'b1;
    pwd       = '0;
    req       = '0;
    kw        = '0;
    pwe       = 1'b0;
    frc       = 1'b0;
    rd_zero   = 1'b0;
    rd_seen   = 0;
    err_total = 0;
    checked   = 0;
    t_match();
    t_ones();
    t_key_reset();
    t_zero();
    print_verdict();
  end

  initial begin
    #1000000;
    err_total++;
    print_verdict();
  end
endmodule : tb_password_unlock_access_guard
